// File: bass_pitch_enhancer_bench.sv
/*
  Testbench of the bass pitch enhancer with the decoder core model.
  Assumes a 25 MHz clock and period-20 samples from the model.
*/
`timescale 1ns/1ps
module bass_pitch_enhancer_bench import bpe_pkg::*;;
  // ******************
  // stimulus and checks
  // ******************
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic IN_VALID, IN_READY, SUB_READY, OUT_VALID, SUB_DONE, BIN_OUT_VALID;
  logic signed [BPE_SW-1:0] IN_SAMPLE, OUT_ENH, BIN_OUT;
  logic [15:0] ALPHA;
  logic SUB_VALID = 1'b0, SUB_ONSET = 1'b0, SUB_K1_FULL = 1'b1;
  logic SUB_LP_MODE = 1'b1, SUB_NB = 1'b0, OUT_READY = 1'b0, BIN_VALID = 1'b0;
  logic [BPE_LAGW-1:0] SUB_LAG = 8'h14;
  logic [9:0] SUB_RATE = 10'h0c8;
  logic [7:0] SUB_NOISE = 8'h00;
  logic [1:0] SUB_GAIN_IDX = 2'h0;
  logic [BPE_BINW-1:0] BIN_IDX = 6'h00;
  logic signed [BPE_SW-1:0] BIN_DEC = 16'sh0000, BIN_ENH = 16'sh0000;
  int bad_count = 0;
  int cmp_count = 0;

  always #20 SYS_CLK = ~SYS_CLK;

  bpe_partner bpe_partner_inst (.clk(SYS_CLK), .rst(RST),
    .in_ready(IN_READY), .in_valid(IN_VALID), .in_sample(IN_SAMPLE));
  // stability, length and k2 tied: alpha stays in the checked ranges only with these
  bpe_top bpe_top_inst (.SYS_CLK(SYS_CLK), .RST(RST), .IN_VALID(IN_VALID),
    .IN_READY(IN_READY), .IN_SAMPLE(IN_SAMPLE), .SUB_VALID(SUB_VALID),
    .SUB_READY(SUB_READY), .SUB_LAG(SUB_LAG), .SUB_FUT_LAG(SUB_LAG),
    .SUB_FUT_VALID(SUB_ONSET), .SUB_ONSET(SUB_ONSET), .SUB_LEN(7'h40),
    .SUB_K1_FULL(SUB_K1_FULL), .SUB_K2_ONE(1'b0), .SUB_RATE(SUB_RATE),
    .SUB_LP_MODE(SUB_LP_MODE), .SUB_NB(SUB_NB), .SUB_NOISE(SUB_NOISE),
    .SUB_STAB(16'h0000), .SUB_GAIN_IDX(SUB_GAIN_IDX), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY), .OUT_ENH(OUT_ENH), .SUB_DONE(SUB_DONE),
    .ALPHA(ALPHA), .BIN_VALID(BIN_VALID), .BIN_IDX(BIN_IDX),
    .BIN_DEC(BIN_DEC), .BIN_ENH(BIN_ENH), .BIN_OUT_VALID(BIN_OUT_VALID),
    .BIN_OUT(BIN_OUT));

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_rng(input string what, input logic [15:0] lo,
      input logic [15:0] hi, input logic [15:0] got);
    cmp_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      bad_count++;
      $display("BAD %s expected %h..%h seen %h", what, lo, hi, got);
    end
  endtask

  task automatic t_reset(input int n);
    @(posedge SYS_CLK);
    RST <= 1'b1;
    repeat (n) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(negedge SYS_CLK);
    chk_rng("alpha", 16'h0000, 16'h0000, ALPHA);
    chk_rng("ready", 16'h0003, 16'h0003, {14'h0, SUB_READY, IN_READY});
    chk_rng("valid", 16'h0000, 16'h0000, {14'h0, OUT_VALID, SUB_DONE});
  endtask

  task automatic bin(input logic [5:0] idx, input logic [15:0] dec,
      input logic [15:0] enh, input logic [15:0] exp);
    @(posedge SYS_CLK);
    BIN_VALID <= 1'b1;
    BIN_IDX <= idx;
    BIN_DEC <= dec;
    BIN_ENH <= enh;
    @(posedge SYS_CLK);
    BIN_VALID <= 1'b0;
    @(negedge SYS_CLK);
    chk_rng("bin_valid", 16'h0001, 16'h0001, {15'h0, BIN_OUT_VALID});
    chk_rng("bin_out", exp, exp, BIN_OUT);
  endtask

  // one subframe of 64, outputs stalled long enough to fill the fifo
  task automatic run_sub(input logic [7:0] lag, input logic onset,
      input logic [9:0] rate, input logic lp, input logic nb,
      input logic [7:0] noise, input logic k1, input logic [1:0] gi,
      input logic [15:0] lo, input logic [15:0] hi);
    int cyc;
    int cnt;
    logic done;
    logic take;
    logic [15:0] tol;
    tol = (hi == 16'h0000) ? 16'h0000 : 16'h0004;
    cnt = 0;
    done = 1'b0;
    @(posedge SYS_CLK);
    SUB_VALID <= 1'b1;
    SUB_LAG <= lag;
    SUB_ONSET <= onset;
    SUB_RATE <= rate;
    SUB_LP_MODE <= lp;
    SUB_NB <= nb;
    SUB_NOISE <= noise;
    SUB_K1_FULL <= k1;
    SUB_GAIN_IDX <= gi;
    OUT_READY <= 1'b0;
    for (cyc = 0; cyc < 2000 && !(done && cnt == 64); cyc++) begin
      @(negedge SYS_CLK);
      if ((OUT_VALID && OUT_READY) === 1'b1) begin
        chk_rng("enh", 16'h0004 - tol, 16'h0004 + tol, OUT_ENH + 16'h0004);
        cnt++;
      end
      if (SUB_DONE === 1'b1) done = 1'b1;
      take = SUB_VALID && SUB_READY;
      @(posedge SYS_CLK);
      if (take) SUB_VALID <= 1'b0;
      OUT_READY <= (cyc >= 250);
    end
    if (!(done && cnt == 64)) begin
      bad_count++;
      $display("BAD sub_end expected 64 seen %0d", cnt);
      complete_run();
    end
    chk_rng("alpha", lo, hi, ALPHA);
    bin(6'h03, 16'h1000, 16'h0100, (hi == 16'h0) ? 16'h1000 : 16'h1100);
  endtask

  task automatic t_bins;
    bin(6'h08, 16'h1234, 16'h0100, 16'h1234);
    bin(6'h07, 16'h7f00, 16'h0200, 16'h7fff);
    bin(6'h00, 16'h8100, 16'hfe00, 16'h8000);
  endtask

  initial begin
    t_reset(5);
    run_sub(8'h14, 1'b0, 10'h0c8, 1'b0, 1'b0, 8'h00, 1'b1, 2'h0, 16'h0, 16'h0);
    run_sub(8'h14, 1'b0, 10'h141, 1'b1, 1'b0, 8'h00, 1'b1, 2'h0, 16'h0, 16'h0);
    run_sub(8'h14, 1'b0, 10'h0c8, 1'b1, 1'b1, 8'h15, 1'b1, 2'h0, 16'h0, 16'h0);
    run_sub(8'h14, 1'b0, 10'h140, 1'b1, 1'b0, 8'h00, 1'b1, 2'h0, 16'h3e00, 16'h4000);
    run_sub(8'h14, 1'b0, 10'h0c8, 1'b1, 1'b1, 8'h14, 1'b1, 2'h1, 16'h3e00, 16'h4000);
    run_sub(8'h14, 1'b0, 10'h0a4, 1'b1, 1'b0, 8'h00, 1'b1, 2'h1, 16'h1e00, 16'h2000);
    run_sub(8'h14, 1'b0, 10'h0f4, 1'b1, 1'b0, 8'h00, 1'b1, 2'h2, 16'h2e00, 16'h3000);
    run_sub(8'h14, 1'b0, 10'h0c8, 1'b1, 1'b0, 8'h00, 1'b0, 2'h3, 16'h3e00, 16'h4000);
    run_sub(8'h28, 1'b0, 10'h0c8, 1'b1, 1'b0, 8'h00, 1'b1, 2'h0, 16'h3e00, 16'h4000);
    run_sub(8'h14, 1'b1, 10'h0c8, 1'b1, 1'b0, 8'h00, 1'b1, 2'h0, 16'h3e00, 16'h4000);
    t_bins;
    t_reset(1);
    complete_run();
  end
endmodule

// File: bpe_checker.sv
/*
  Port checker of the bass pitch enhancer, bound into bpe_top.
  Assumes one clock, SYS_CLK, and the synchronous reset RST.
*/
`timescale 1ns/1ps
module bpe_checker import bpe_pkg::*; #(
  parameter logic [BPE_BINW-1:0] LB_BANDS = 6'h08
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic IN_READY,
  input wire logic SUB_VALID,
  input wire logic SUB_READY,
  input wire logic OUT_VALID,
  input wire logic OUT_READY,
  input wire logic signed [BPE_SW-1:0] OUT_ENH,
  input wire logic SUB_DONE,
  input wire logic [15:0] ALPHA,
  input wire logic BIN_VALID,
  input wire logic [BPE_BINW-1:0] BIN_IDX,
  input wire logic signed [BPE_SW-1:0] BIN_DEC,
  input wire logic BIN_OUT_VALID,
  input wire logic signed [BPE_SW-1:0] BIN_OUT
);
  // ******************
  // properties
  // ******************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  property p_rst_vals;
    $past(RST) |-> IN_READY && SUB_READY && !OUT_VALID && ALPHA == 16'h0000;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("outputs not at reset values");
  property p_sub_busy;
    SUB_VALID && SUB_READY |=> !SUB_READY;
  endproperty
  a_sub_busy: assert property (p_sub_busy)
    else $error("descriptor taken while busy");
  property p_done;
    SUB_DONE |-> SUB_READY ##1 !SUB_DONE;
  endproperty
  a_done: assert property (p_done)
    else $error("done pulse or ready release wrong");
  property p_alpha_hold;
    $changed(ALPHA) && !$past(RST) |-> !SUB_READY;
  endproperty
  a_alpha_hold: assert property (p_alpha_hold)
    else $error("factor changed outside a subframe");
  // clamp of one half, times at most 1.15 from stability
  property p_alpha_max;
    ALPHA <= 16'h49a0;
  endproperty
  a_alpha_max: assert property (p_alpha_max)
    else $error("factor above its bound");
  property p_out_hold;
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_ENH);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("stalled sample lost or changed");
  property p_bin_lat;
    BIN_VALID |=> BIN_OUT_VALID;
  endproperty
  a_bin_lat: assert property (p_bin_lat)
    else $error("bin answer missing");
  property p_bin_only;
    !BIN_VALID |=> !BIN_OUT_VALID;
  endproperty
  a_bin_only: assert property (p_bin_only)
    else $error("bin answer without request");
  property p_bin_hi;
    BIN_VALID && BIN_IDX >= LB_BANDS |=> BIN_OUT == $past(BIN_DEC);
  endproperty
  a_bin_hi: assert property (p_bin_hi)
    else $error("upper bin modified");
endmodule

bind bpe_top bpe_checker #(.LB_BANDS(LB_BANDS)) bpe_checker_inst (
  .SYS_CLK(SYS_CLK), .RST(RST), .IN_READY(IN_READY),
  .SUB_VALID(SUB_VALID), .SUB_READY(SUB_READY), .OUT_VALID(OUT_VALID),
  .OUT_READY(OUT_READY), .OUT_ENH(OUT_ENH), .SUB_DONE(SUB_DONE),
  .ALPHA(ALPHA), .BIN_VALID(BIN_VALID), .BIN_IDX(BIN_IDX),
  .BIN_DEC(BIN_DEC), .BIN_OUT_VALID(BIN_OUT_VALID), .BIN_OUT(BIN_OUT)
);

// File: bpe_partner.sv
/*
  Decoder core model: streams decoded samples of period 20.
  Assumes the enhancer takes a sample when in_valid and in_ready.
*/
`timescale 1ns/1ps
module bpe_partner import bpe_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_ready,
  output logic in_valid,
  output logic signed [BPE_SW-1:0] in_sample
);
  // ******************
  // sample stream
  // ******************
  logic [4:0] ph_r;
  // runs ahead of the subframes so future pitch cycles exist
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_r <= 5'h00;
    end else if (in_valid && in_ready) begin
      ph_r <= (ph_r == 5'h13) ? 5'h00 : ph_r + 5'h01;
    end
  end
  assign in_valid = !rst;
  assign in_sample = BPE_SW'(int'(ph_r) * 800 - 8000);
endmodule

// File: bpe_pkg.sv
/*
  Shared constants of the bass pitch enhancer: widths, fixed-point
  coefficients, rate thresholds and the state encoding.
  Assumes Q15 coefficients and rates given in units of 0.1 kbit/s.
*/
package bpe_pkg;

  // ***************************************************************
  // widths
  // ***************************************************************
  localparam int BPE_SW = 16;
  localparam int BPE_LAGW = 8;
  localparam int BPE_LENW = 7;
  localparam int BPE_AW = 10;
  localparam int BPE_ACCW = 48;
  localparam int BPE_EPPW = 24;
  localparam int BPE_BINW = 6;

  // ***************************************************************
  // fixed-point constants, Q15 unless noted
  // ***************************************************************
  localparam logic [15:0] BPE_Q_ONE = 16'h7fff;
  localparam logic [15:0] BPE_Q_HALF = 16'h4000;
  localparam logic [15:0] BPE_C_0P9 = 16'h7333;
  localparam logic [15:0] BPE_C_0P99 = 16'h7eb8;
  localparam logic [15:0] BPE_C_0P01 = 16'h0148;
  localparam logic [15:0] BPE_C_0P8 = 16'h6666;
  localparam logic [15:0] BPE_C_0P2 = 16'h199a;
  localparam logic [15:0] BPE_C_0P15 = 16'h1333;
  // 10*log10(2) in Q8, and 0.1/log10(2) in Q8
  localparam logic [15:0] BPE_DB_PER_LOG2 = 16'h0303;
  localparam logic [15:0] BPE_LOG2_PER_DB = 16'h0055;
  localparam logic [16:0] BPE_SCALE_ONE = 17'h08000;
  localparam logic [5:0] BPE_FLOOR_EXP_MAX = 6'h2e;
  localparam logic [3:0] BPE_DIV_STEPS = 4'hf;

  // ***************************************************************
  // operating points
  // ***************************************************************
  localparam logic [9:0] BPE_RATE_MAX = 10'h140;
  localparam logic [9:0] BPE_RATE_GA_LO = 10'h0a4;
  localparam logic [9:0] BPE_RATE_GA_HI = 10'h0f4;
  localparam logic [7:0] BPE_NOISE_NB_MAX = 8'h14;

  // ***************************************************************
  // states
  // ***************************************************************
  typedef enum logic [2:0] {
    BPE_IDLE = 3'b000,
    BPE_WAIT = 3'b001,
    BPE_ACC = 3'b010,
    BPE_DIV1 = 3'b011,
    BPE_ERR = 3'b100,
    BPE_DIV2 = 3'b101,
    BPE_SCALE = 3'b110,
    BPE_OUT = 3'b111
  } bpe_state_e;

endpackage

// File: bpe_top.sv
/*
  Bass pitch enhancer: the output FIFO and the top module, which
  buffers decoded samples, runs the per-subframe pitch enhancer and
  adds the low band of the enhancement to decoded spectrum bins.
  Assumes one clock, a synchronous reset, and an external filter bank
  that turns the emitted enhancement samples into bins.
*/
`timescale 1ns/1ps

// ***************************************************************
// fifo
// ***************************************************************
module bpe_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [PW-1:0] rd_r, rd_nxt, wr_r, wr_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != (PW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_r <= '0;
      wr_r <= '0;
      cnt_r <= '0;
    end else begin
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
endmodule

// ***************************************************************
// top
// ***************************************************************
module bpe_top import bpe_pkg::*; #(
  parameter int FIFO_DEPTH = 16,
  parameter logic [BPE_BINW-1:0] LB_BANDS = 6'h08,
  parameter logic [BPE_LAGW-1:0] TRK_TOL = 8'h04,
  // dequantized adjustment per index, Q15
  parameter logic [15:0] GADJ0 = 16'h2000,
  parameter logic [15:0] GADJ1 = 16'h4000,
  parameter logic [15:0] GADJ2 = 16'h6000,
  parameter logic [15:0] GADJ3 = 16'h7fff
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic signed [BPE_SW-1:0] IN_SAMPLE,
  input wire logic SUB_VALID,
  output logic SUB_READY,
  input wire logic [BPE_LAGW-1:0] SUB_LAG,
  input wire logic [BPE_LAGW-1:0] SUB_FUT_LAG,
  input wire logic SUB_FUT_VALID,
  input wire logic SUB_ONSET,
  input wire logic [BPE_LENW-1:0] SUB_LEN,
  input wire logic SUB_K1_FULL,
  input wire logic SUB_K2_ONE,
  input wire logic [9:0] SUB_RATE,
  input wire logic SUB_LP_MODE,
  input wire logic SUB_NB,
  input wire logic [7:0] SUB_NOISE,
  input wire logic [15:0] SUB_STAB,
  input wire logic [1:0] SUB_GAIN_IDX,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic signed [BPE_SW-1:0] OUT_ENH,
  output logic SUB_DONE,
  output logic [15:0] ALPHA,
  input wire logic BIN_VALID,
  input wire logic [BPE_BINW-1:0] BIN_IDX,
  input wire logic signed [BPE_SW-1:0] BIN_DEC,
  input wire logic signed [BPE_SW-1:0] BIN_ENH,
  output logic BIN_OUT_VALID,
  output logic signed [BPE_SW-1:0] BIN_OUT
);
  localparam int DEPTH = 2**BPE_AW;
  localparam logic [BPE_AW-1:0] OCC_MAX = BPE_AW'(DEPTH - 2**BPE_LAGW - 1);

  function automatic logic signed [BPE_ACCW-1:0] sat_add(
      input logic signed [BPE_ACCW-1:0] a, input logic signed [BPE_ACCW-1:0] b);
    logic signed [BPE_ACCW:0] s;
    s = {a[BPE_ACCW-1], a} + {b[BPE_ACCW-1], b};
    if (s[BPE_ACCW] != s[BPE_ACCW-1])
      sat_add = {s[BPE_ACCW], {(BPE_ACCW-1){~s[BPE_ACCW]}}};
    else
      sat_add = s[BPE_ACCW-1:0];
  endfunction

  function automatic logic signed [BPE_SW-1:0] sat16(
      input logic signed [31:0] v);
    if (v > 32'sh7fff) sat16 = 16'sh7fff;
    else if (v < -32'sh8000) sat16 = -16'sh8000;
    else sat16 = v[15:0];
  endfunction

  function automatic logic [15:0] isqrt(input logic [31:0] x);
    logic [31:0] rem;
    logic [15:0] root;
    logic [17:0] trial;
    rem = '0;
    root = '0;
    trial = '0;
    for (int i = 15; i >= 0; i--) begin
      rem = {rem[29:0], x[2*i+1], x[2*i]};
      trial = {root, 2'b01};
      if (rem[17:0] >= trial && rem[31:18] == '0) begin
        rem = rem - {14'h0, trial};
        root = {root[14:0], 1'b1};
      end else begin
        root = {root[14:0], 1'b0};
      end
    end
    isqrt = root;
  endfunction

  logic signed [BPE_SW-1:0] smem_r [DEPTH];
  bpe_state_e st_r, st_nxt;
  logic [BPE_AW-1:0] base_r, base_nxt, wr_r, wr_nxt, occ;
  logic [BPE_LENW-1:0] n_r, n_nxt, len_r, len_nxt;
  logic [BPE_LAGW-1:0] tp_r, tp_nxt, tf_r, tf_nxt, prev_r, prev_nxt;
  logic k1_r, k1_nxt, k2_r, k2_nxt, byp_r, byp_nxt, gadj_r, gadj_nxt;
  logic [15:0] gain_r, gain_nxt, stab_r, stab_nxt, smst_r, smst_nxt;
  logic signed [BPE_ACCW-1:0] cp_r, cp_nxt, ep_r, ep_nxt, ee_r, ee_nxt;
  logic signed [BPE_EPPW-1:0] epp_r, epp_nxt, ebar_r, ebar_nxt;
  logic signed [15:0] ratio_r, ratio_nxt;
  logic [15:0] alpha_r, alpha_nxt;
  logic [BPE_ACCW:0] rem_r, rem_nxt;
  logic [BPE_ACCW-1:0] den_r, den_nxt;
  logic [15:0] quo_r, quo_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic neg_r, neg_nxt, done_r, done_nxt, binv_r, binv_nxt;
  logic signed [BPE_SW-1:0] bin_r, bin_nxt;
  logic signed [BPE_SW-1:0] s_cur, s_past, s_fut, sp;
  logic [BPE_LAGW-1:0] lag_trk, lag_half;
  logic [BPE_LAGW:0] lag_dbl;
  logic fifo_rdy, fifo_push, last;
  logic signed [BPE_SW-1:0] enh;
  logic signed [BPE_ACCW-1:0] num2, floor_v;
  logic [47:0] ee_u;
  logic [5:0] msb;
  logic [7:0] frac;
  logic [13:0] log2_q8;
  logic signed [39:0] tmp40;
  logic signed [39:0] flr40;
  logic signed [31:0] tmp32;
  logic signed [17:0] ep_s;
  logic [32:0] scl;

  // ***************************************************************
  // sample buffer
  // ***************************************************************
  assign occ = wr_r - base_r;
  // past lags must survive until their subframe has been processed
  assign IN_READY = (occ < OCC_MAX);
  assign SUB_READY = (st_r == BPE_IDLE);
  assign s_cur = smem_r[base_r + BPE_AW'(n_r)];
  assign s_past = smem_r[base_r + BPE_AW'(n_r) - BPE_AW'(tp_r)];
  assign s_fut = smem_r[base_r + BPE_AW'(n_r) + BPE_AW'(tf_r)];
  // prediction = half past + half future
  assign sp = BPE_SW'(({s_past[BPE_SW-1], s_past} +
                       {s_fut[BPE_SW-1], s_fut}) >>> 1);
  assign last = (n_r == len_r - 1'b1);
  // r = (1-a)s + a*sp - s = a*(sp - s)
  assign tmp32 = $signed({1'b0, alpha_r}) *
                 (32'(sp) - 32'(s_cur));
  assign enh = sat16(tmp32 >>> 15);
  assign fifo_push = (st_r == BPE_OUT);

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      for (int i = 0; i < DEPTH; i++) smem_r[i] <= '0;
    end else if (IN_VALID && IN_READY) begin
      smem_r[wr_r] <= IN_SAMPLE;
    end
  end

  // ***************************************************************
  // pitch tracker
  // ***************************************************************
  always_comb begin
    lag_dbl = {prev_r, 1'b0};
    lag_half = SUB_LAG;
    // a lag near twice the last one is taken as doubling
    if (prev_r != '0 && {1'b0, SUB_LAG} + (BPE_LAGW+1)'(TRK_TOL) >= lag_dbl &&
        {1'b0, SUB_LAG} <= lag_dbl + (BPE_LAGW+1)'(TRK_TOL))
      lag_half = SUB_LAG >> 1;
    lag_trk = lag_half;
    if (prev_r != '0 && (lag_half > prev_r ? lag_half - prev_r :
        prev_r - lag_half) <= TRK_TOL)
      lag_trk = BPE_LAGW'(({1'b0, lag_half} + {1'b0, prev_r} + 1'b1) >> 1);
  end

  // ***************************************************************
  // energy to dB and floor term
  // ***************************************************************
  always_comb begin
    ee_u = ee_r;
    msb = '0;
    for (int i = 0; i < 48; i++) if (ee_u[i]) msb = 6'(i);
    frac = 8'((ee_u << (6'd47 - msb)) >> 39);
    log2_q8 = (ee_u == '0) ? '0 : {msb, frac};
    flr40 = $signed(40'(ebar_r)) * $signed({1'b0, BPE_LOG2_PER_DB});
    floor_v = 48'sh1;
    if (flr40 > 0) begin
      if ((flr40 >>> 16) > 40'(BPE_FLOOR_EXP_MAX))
        floor_v = 48'sh1 << BPE_FLOOR_EXP_MAX;
      else
        floor_v = 48'sh1 << flr40[21:16];
    end
    // k1 halves the correlation at the other operating point
    num2 = k1_r ? cp_r : (cp_r >>> 1);
  end

  // ***************************************************************
  // subframe sequencer and datapath
  // ***************************************************************
  always_comb begin
    st_nxt = st_r;
    base_nxt = base_r;
    wr_nxt = (IN_VALID && IN_READY) ? wr_r + 1'b1 : wr_r;
    n_nxt = n_r;
    {len_nxt, tp_nxt, tf_nxt, prev_nxt} = {len_r, tp_r, tf_r, prev_r};
    {k1_nxt, k2_nxt, byp_nxt, gadj_nxt} = {k1_r, k2_r, byp_r, gadj_r};
    {gain_nxt, stab_nxt, smst_nxt} = {gain_r, stab_r, smst_r};
    {cp_nxt, ep_nxt, ee_nxt, epp_nxt, ebar_nxt} =
        {cp_r, ep_r, ee_r, epp_r, ebar_r};
    {ratio_nxt, alpha_nxt, rem_nxt, den_nxt} =
        {ratio_r, alpha_r, rem_r, den_r};
    {quo_nxt, cnt_nxt, neg_nxt} = {quo_r, cnt_r, neg_r};
    done_nxt = 1'b0;
    ep_s = '0;
    scl = '0;
    tmp40 = '0;
    unique case (st_r)
      BPE_IDLE: if (SUB_VALID) begin
        // configuration held for the whole subframe
        len_nxt = (SUB_LEN == '0) ? 7'h01 : SUB_LEN;
        tp_nxt = lag_trk;
        tf_nxt = (SUB_ONSET && SUB_FUT_VALID) ? SUB_FUT_LAG : lag_trk;
        prev_nxt = lag_trk;
        {k1_nxt, k2_nxt, stab_nxt} = {SUB_K1_FULL, SUB_K2_ONE, SUB_STAB};
        byp_nxt = !SUB_LP_MODE || SUB_RATE > BPE_RATE_MAX ||
                  (SUB_NB && SUB_NOISE > BPE_NOISE_NB_MAX);
        gadj_nxt = (SUB_RATE == BPE_RATE_GA_LO) || (SUB_RATE == BPE_RATE_GA_HI);
        gain_nxt = SUB_GAIN_IDX == 2'h0 ? GADJ0 : SUB_GAIN_IDX == 2'h1 ? GADJ1 :
                   SUB_GAIN_IDX == 2'h2 ? GADJ2 : GADJ3;
        {cp_nxt, ep_nxt, ee_nxt, n_nxt} = '0;
        st_nxt = BPE_WAIT;
      end
      BPE_WAIT: if ({1'b0, occ} >= (BPE_AW+1)'(len_r) + (BPE_AW+1)'(tf_r))
        st_nxt = BPE_ACC;
      BPE_ACC: begin
        cp_nxt = sat_add(cp_r, BPE_ACCW'(32'(s_cur) * 32'(sp)));
        ep_nxt = sat_add(ep_r, BPE_ACCW'(32'(sp) * 32'(sp)));
        n_nxt = n_r + 1'b1;
        if (last) begin
          n_nxt = '0;
          neg_nxt = cp_nxt[BPE_ACCW-1];
          rem_nxt = {1'b0, neg_nxt ? -cp_nxt : cp_nxt};
          den_nxt = ep_nxt;
          {quo_nxt, cnt_nxt} = {16'h0, BPE_DIV_STEPS};
          st_nxt = BPE_DIV1;
        end
      end
      BPE_DIV1, BPE_DIV2: begin
        // serial Q15 divide, saturates once the quotient reaches one
        if (den_r == '0) begin
          quo_nxt = '0;
          cnt_nxt = '0;
        end else if (cnt_r == BPE_DIV_STEPS && rem_r >= {1'b0, den_r}) begin
          quo_nxt = BPE_Q_ONE;
          cnt_nxt = '0;
        end else if (cnt_r != '0) begin
          rem_nxt = rem_r << 1;
          quo_nxt = {quo_r[14:0], rem_nxt >= {1'b0, den_r}};
          if (rem_nxt >= {1'b0, den_r}) rem_nxt = rem_nxt - {1'b0, den_r};
          cnt_nxt = cnt_r - 1'b1;
        end
        if (den_r == '0 || cnt_r == '0 || rem_r >= {1'b0, den_r}) begin
          if (st_r == BPE_DIV1) begin
            ratio_nxt = neg_r ? -$signed(quo_nxt) : $signed(quo_nxt);
            st_nxt = BPE_ERR;
          end else begin
            // clamp to [0, 0.5]
            alpha_nxt = neg_r ? 16'h0 :
                        (quo_nxt > BPE_Q_HALF ? BPE_Q_HALF : quo_nxt);
            st_nxt = BPE_SCALE;
          end
        end
      end
      BPE_ERR: begin
        ep_s = k2_r ? 18'(s_cur) : 18'((32'(ratio_r) * 32'(s_cur)) >>> 15);
        ep_s = ep_s - 18'((32'(ratio_r) * 32'(sp)) >>> 15);
        tmp40 = 40'(epp_r) * $signed({1'b0, BPE_C_0P9});
        tmp40 = (tmp40 >>> 15) + 40'(ep_s);
        epp_nxt = (tmp40 > 40'sh7fffff) ? 24'sh7fffff :
                  (tmp40 < -40'sh800000) ? -24'sh800000 : tmp40[23:0];
        ee_nxt = sat_add(ee_r, BPE_ACCW'(epp_nxt) * BPE_ACCW'(epp_nxt));
        n_nxt = n_r + 1'b1;
        if (last) begin
          n_nxt = '0;
          neg_nxt = (num2 <= 0);
          rem_nxt = {1'b0, num2};
          den_nxt = sat_add(ep_r, floor_v);
          {quo_nxt, cnt_nxt} = {16'h0, BPE_DIV_STEPS};
          st_nxt = BPE_DIV2;
        end
      end
      BPE_SCALE: begin
        // floor used the old mean; update it now
        tmp40 = $signed({1'b0, log2_q8}) * $signed({1'b0, BPE_DB_PER_LOG2});
        tmp40 = 40'(ebar_r) * $signed({1'b0, BPE_C_0P99}) +
                (tmp40 >>> 8) * $signed({1'b0, BPE_C_0P01});
        ebar_nxt = 24'(tmp40 >>> 15);
        smst_nxt = 16'((32'(stab_r) * 32'(BPE_C_0P8) +
                        32'(smst_r) * 32'(BPE_C_0P2)) >> 15);
        scl = 33'(BPE_SCALE_ONE) +
              33'((32'(isqrt({1'b0, stab_r[14:0], 16'h0} >> 1)) *
                   32'(BPE_C_0P15)) >> 15);
        scl = scl - 33'({(smst_nxt > stab_r ? smst_nxt - stab_r :
                          stab_r - smst_nxt), 1'b0});
        if (scl[32]) scl = '0;
        scl = (33'(alpha_r) * scl) >> 15;
        if (gadj_r) scl = (scl * 33'(gain_r)) >> 15;
        alpha_nxt = byp_r ? 16'h0 : (scl > 33'(BPE_Q_ONE) ? BPE_Q_ONE : scl[15:0]);
        st_nxt = BPE_OUT;
      end
      BPE_OUT: if (fifo_rdy) begin
        n_nxt = n_r + 1'b1;
        if (last) begin
          n_nxt = '0;
          base_nxt = base_r + BPE_AW'(len_r);
          done_nxt = 1'b1;
          st_nxt = BPE_IDLE;
        end
      end
    endcase
    // frequency domain mix, low bands only
    binv_nxt = BIN_VALID;
    bin_nxt = bin_r;
    if (BIN_VALID)
      bin_nxt = (BIN_IDX < LB_BANDS && !byp_r) ?
                sat16(32'(BIN_DEC) + 32'(BIN_ENH)) : BIN_DEC;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_r <= BPE_IDLE;
      {base_r, wr_r, n_r, len_r, tp_r, tf_r, prev_r} <= '0;
      {k1_r, k2_r, byp_r, gadj_r, gain_r, stab_r} <= '0;
      {smst_r, epp_r, ebar_r} <= '0;
      {cp_r, ep_r, ee_r, ratio_r, alpha_r} <= '0;
      {rem_r, den_r, quo_r, cnt_r, neg_r, done_r, binv_r, bin_r} <= '0;
    end else begin
      st_r <= st_nxt;
      {base_r, wr_r, n_r, len_r, tp_r, tf_r, prev_r} <=
          {base_nxt, wr_nxt, n_nxt, len_nxt, tp_nxt, tf_nxt, prev_nxt};
      {k1_r, k2_r, byp_r, gadj_r, gain_r, stab_r} <=
          {k1_nxt, k2_nxt, byp_nxt, gadj_nxt, gain_nxt, stab_nxt};
      {smst_r, epp_r, ebar_r} <= {smst_nxt, epp_nxt, ebar_nxt};
      {cp_r, ep_r, ee_r, ratio_r, alpha_r} <=
          {cp_nxt, ep_nxt, ee_nxt, ratio_nxt, alpha_nxt};
      {rem_r, den_r, quo_r, cnt_r, neg_r, done_r, binv_r, bin_r} <=
          {rem_nxt, den_nxt, quo_nxt, cnt_nxt, neg_nxt, done_nxt,
           binv_nxt, bin_nxt};
    end
  end

  assign SUB_DONE = done_r;
  assign ALPHA = alpha_r;
  assign BIN_OUT_VALID = binv_r;
  assign BIN_OUT = bin_r;

  bpe_fifo #(.W(BPE_SW), .D(FIFO_DEPTH)) bpe_fifo_inst (
    .clk(SYS_CLK),
    .rst(RST),
    .in_valid(fifo_push),
    .in_ready(fifo_rdy),
    .in_data(enh),
    .out_valid(OUT_VALID),
    .out_ready(OUT_READY),
    .out_data(OUT_ENH)
  );
endmodule
